// *** hdl/dcd_top.sv ***
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dcd_top (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [dcd_pkg::AddrW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [dcd_pkg::AddrW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      strobe,
    input  wire logic                      ampEnabled,
    input  wire logic                      ampFollower,
    output logic [dcd_pkg::BinW-1:0]       binSel,
    output logic [dcd_pkg::ThermW-1:0]     thermSel,
    output logic                           supplyRefSwitch,
    output logic                           opampRefSwitch,
    output logic                           holdCapSwitch,
    output logic                           emptyIrq,
    output logic                           dmaTrig
);
    import dcd_pkg::*;

    function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [AddrW-1:0] a,
                                 input logic [AddrW-1:0] off);
        return {a[AddrW-1:2], 2'b00} == off;
    endfunction

    // write channel state
    logic             awHeld_q;
    logic [AddrW-1:0] awAddr_q;
    logic             wHeld_q;
    logic [31:0]      wData_q;
    logic [3:0]       wStrb_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    // read channel state
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;
    // block registers
    logic [31:0]      ctrl_q;
    logic [DivW-1:0]  div_q;
    logic [SwW-1:0]   sw_q;
    logic [CodeW-1:0] code_q;
    logic [CodeW-1:0] next_q;
    logic             nextFull_q;
    logic             empty_q;
    logic             dmaTrig_q;
    logic             opRef_q;

    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    wire logic doWrite = awHeld_q && wHeld_q;
    wire logic wrCtrl  = doWrite && hit(awAddr_q, OffCtrl);
    wire logic wrDiv   = doWrite && hit(awAddr_q, OffDiv);
    wire logic wrSet   = doWrite && hit(awAddr_q, OffSwSet);
    wire logic wrClr   = doWrite && hit(awAddr_q, OffSwClr);
    wire logic wrCode  = doWrite && hit(awAddr_q, OffCode);
    wire logic wrNext  = doWrite && hit(awAddr_q, OffNext);
    wire logic wrMapped = wrCtrl | wrDiv | wrSet | wrClr | wrCode | wrNext
                        | hit(awAddr_q, OffStat);

    wire logic [31:0] wMerged = applyStrb(32'h0000_0000, wData_q, wStrb_q);
    wire logic [31:0] ctrlD   = applyStrb(ctrl_q, wData_q, wStrb_q) & CtrlMask;
    wire logic [31:0] divW    = applyStrb({16'h0000, div_q}, wData_q, wStrb_q);
    wire logic [31:0] codeW   = applyStrb({20'h0_0000, code_q}, wData_q,
                                          wStrb_q);
    wire logic [31:0] nextW   = applyStrb({20'h0_0000, next_q}, wData_q,
                                          wStrb_q);

    wire logic       bufMode   = ctrl_q[BufModeBit];
    wire logic [1:0] fmt       = ctrl_q[FmtLsb +: 2];
    wire logic       strobeEn  = ctrl_q[StrobeEnBit];
    wire logic       strobeLvl = ctrl_q[StrobeLvlBit];

    // update timing: clock divider and strobe modes
    logic updReq;
    dcd_update_ctrl u_upd (
        .clk         (clk),
        .rst_n       (rst_n),
        .divisor     (div_q),
        .strobeEn    (strobeEn),
        .strobeLevel (strobeLvl),
        .strobe      (strobe),
        .loadReq     (updReq)
    );

    wire logic load = updReq && bufMode;

    // switch set and clear, one write at a time
    wire logic [SwW-1:0] setBits = wrSet ? wMerged[SwW-1:0] : '0;
    wire logic [SwW-1:0] clrBits = wrClr ? wMerged[SwW-1:0] : '0;
    wire logic [SwW-1:0] swD     = (sw_q | setBits) & ~clrBits;

    // format conversion into ladder domain
    wire logic [CodeW-1:0] ladderCode =
        (fmt == FmtTwos) ? (code_q ^ SignFlip) : code_q;

    dcd_therm_dec u_dec (
        .clk      (clk),
        .rst_n    (rst_n),
        .code     (ladderCode),
        .binSel   (binSel),
        .thermSel (thermSel)
    );

    // read mux
    wire logic rdMapped = hit(s_axi_araddr, OffCtrl)
                        | hit(s_axi_araddr, OffDiv)
                        | hit(s_axi_araddr, OffSwSet)
                        | hit(s_axi_araddr, OffSwClr)
                        | hit(s_axi_araddr, OffCode)
                        | hit(s_axi_araddr, OffNext)
                        | hit(s_axi_araddr, OffStat);
    wire logic [31:0] rdVal =
        hit(s_axi_araddr, OffCtrl)  ? ctrl_q :
        hit(s_axi_araddr, OffDiv)   ? {16'h0000, div_q} :
        hit(s_axi_araddr, OffSwSet) ? {29'h0000_0000, sw_q} :
        hit(s_axi_araddr, OffCode)  ? {20'h0_0000, code_q} :
        hit(s_axi_araddr, OffNext)  ? {20'h0_0000, next_q} :
        hit(s_axi_araddr, OffStat)  ? {30'h0000_0000, nextFull_q, empty_q} :
                                      32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
            wHeld_q  <= 1'b0;
            wData_q  <= 32'h0000_0000;
            wStrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= RespOkay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
            if (doWrite) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wrMapped ? RespOkay : RespSlvErr;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RespOkay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rdVal;
            rresp_q  <= rdMapped ? RespOkay : RespSlvErr;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q     <= CtrlRst;
            div_q      <= DivRst;
            sw_q       <= '0;
            code_q     <= CodeRst;
            next_q     <= CodeRst;
            nextFull_q <= 1'b0;
            empty_q    <= 1'b0;
            dmaTrig_q  <= 1'b0;
            opRef_q    <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= ctrlD;
            end
            if (wrDiv) begin
                div_q <= divW[DivW-1:0];
            end
            if (wrNext) begin
                next_q <= nextW[CodeW-1:0];
            end
            if (load) begin
                code_q <= next_q;
            end else if (wrCode) begin
                code_q <= codeW[CodeW-1:0];
            end
            sw_q       <= swD;
            nextFull_q <= wrNext | (nextFull_q & ~load);
            empty_q    <= load | (empty_q & ~wrNext);
            dmaTrig_q  <= load;
            opRef_q    <= swD[OpampRefBit] & ampEnabled & ampFollower;
        end
    end

    assign supplyRefSwitch = sw_q[SupplyRefBit];
    assign opampRefSwitch  = opRef_q;
    assign holdCapSwitch   = sw_q[HoldCapBit];
    assign emptyIrq        = empty_q;
    assign dmaTrig         = dmaTrig_q;

    a_bin_direct: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> binSel == $past(ladderCode[BinW-1:0]))
        else $error("binary ladder lines differ from code");

    a_therm_count: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> ($countones(thermSel) == $past(ladderCode[11:8]))
            && (((thermSel + 15'h0001) & thermSel) == 15'h0000))
        else $error("thermometer lines wrong");

    a_therm_zero: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(ladderCode[11:8]) == 4'h0 |-> thermSel == '0)
        else $error("thermometer not clear for zero nibble");

    a_supply_set: assert property (@(posedge clk) disable iff (!rst_n)
        wrSet && wMerged[SupplyRefBit] |=> supplyRefSwitch)
        else $error("supply reference switch not closed");

    a_opamp_gate: assert property (@(posedge clk) disable iff (!rst_n)
        opampRefSwitch |-> $past(ampEnabled && ampFollower))
        else $error("opamp reference closed without follower");

    a_hold_set: assert property (@(posedge clk) disable iff (!rst_n)
        wrSet && wMerged[HoldCapBit] && !wrClr |=> holdCapSwitch)
        else $error("hold switch not closed");

    a_code_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $changed(code_q) |-> $past(load || wrCode))
        else $error("code changed without write or update");

    a_twos_map: assert property (@(posedge clk) disable iff (!rst_n)
        code_q == 12'h800 && fmt == FmtTwos |-> ladderCode == 12'h000)
        else $error("two's complement low code not mapped to zero");

    a_update_copy: assert property (@(posedge clk) disable iff (!rst_n)
        load |=> dmaTrig && emptyIrq && code_q == $past(next_q)
            ##1 dmaTrig == $past(load))
        else $error("buffered update wrong");

    a_empty_clear: assert property (@(posedge clk) disable iff (!rst_n)
        wrNext && !load |=> !emptyIrq)
        else $error("empty flag not cleared by next write");

    a_switch_open: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(supplyRefSwitch) |-> $past(wrClr && wMerged[SupplyRefBit]))
        else $error("switch opened without clear write");
endmodule
`default_nettype wire

// *** hdl/dcd_pkg.sv ***
package dcd_pkg;
    localparam int CodeW  = 12;
    localparam int BinW   = 8;
    localparam int ThermW = 15;
    localparam int NibW   = 4;
    localparam int AddrW  = 5;
    localparam int DivW   = 16;
    localparam int SwW    = 3;

    // register byte offsets
    localparam logic [AddrW-1:0] OffCtrl  = 5'h00;
    localparam logic [AddrW-1:0] OffDiv   = 5'h04;
    localparam logic [AddrW-1:0] OffSwSet = 5'h08;
    localparam logic [AddrW-1:0] OffSwClr = 5'h0C;
    localparam logic [AddrW-1:0] OffCode  = 5'h10;
    localparam logic [AddrW-1:0] OffNext  = 5'h14;
    localparam logic [AddrW-1:0] OffStat  = 5'h18;

    // control register fields
    localparam int BufModeBit   = 0;
    localparam int FmtLsb       = 24;
    localparam int StrobeEnBit  = 28;
    localparam int StrobeLvlBit = 29;
    localparam logic [31:0] CtrlMask = 32'h3300_0001;
    localparam logic [31:0] CtrlRst  = 32'h0000_0000;

    // switch bits
    localparam int SupplyRefBit = 0;
    localparam int OpampRefBit  = 1;
    localparam int HoldCapBit   = 2;

    // code formats
    localparam logic [1:0] FmtUnsigned = 2'h0;
    localparam logic [1:0] FmtTwos     = 2'h1;
    localparam logic [CodeW-1:0] SignFlip = 12'h800;

    localparam logic [DivW-1:0]  DivRst  = 16'h0001;
    localparam logic [CodeW-1:0] CodeRst = 12'h000;

    localparam logic [1:0] RespOkay   = 2'h0;
    localparam logic [1:0] RespSlvErr = 2'h2;
endpackage

// *** hdl/dcd_therm_dec.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcd_therm_dec (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [dcd_pkg::CodeW-1:0] code,
    output logic      [dcd_pkg::BinW-1:0]  binSel,
    output logic      [dcd_pkg::ThermW-1:0] thermSel
);
    import dcd_pkg::*;

    // n lines set from the lsb upward
    function automatic logic [ThermW-1:0] thermOf(input logic [NibW-1:0] n);
        logic [ThermW-1:0] t;
        t = '0;
        for (int i = 0; i < ThermW; i++) begin
            t[i] = (n > NibW'(i));
        end
        return t;
    endfunction

    wire logic [ThermW-1:0] thermD = thermOf(code[CodeW-1:BinW]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            binSel   <= '0;
            thermSel <= '0;
        end else begin
            binSel   <= code[BinW-1:0];
            thermSel <= thermD;
        end
    end
endmodule
`default_nettype wire

// *** hdl/dcd_update_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcd_update_ctrl (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [dcd_pkg::DivW-1:0] divisor,
    input  wire logic                     strobeEn,
    input  wire logic                     strobeLevel,
    input  wire logic                     strobe,
    output logic                          loadReq
);
    import dcd_pkg::*;

    logic [DivW-1:0] cnt_q;
    logic            strobePrev_q;
    logic            armed_q;

    // update clock rising edge as a one-cycle tick
    wire logic tick = ({1'b0, cnt_q} + 17'h0_0001) >= {1'b0, divisor};
    wire logic strobeRise = strobe & ~strobePrev_q;
    wire logic armedNow = armed_q | strobeRise;

    assign loadReq = !strobeEn   ? tick :
                     strobeLevel ? (tick & strobe) :
                                   (tick & armedNow);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q        <= '0;
            strobePrev_q <= 1'b0;
            armed_q      <= 1'b0;
        end else begin
            cnt_q        <= tick ? '0 : cnt_q + 16'h0001;
            strobePrev_q <= strobe;
            armed_q      <= armedNow & ~tick;
        end
    end
endmodule
`default_nettype wire

// *** verification/dcd_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcd_top_test;
    import dcd_pkg::*;
    logic             clk;
    logic             rst_n;
    logic [AddrW-1:0] awAddr;
    logic [AddrW-1:0] arAddr;
    logic [31:0]      wData;
    logic [31:0]      rData;
    logic [31:0]      lastData;
    logic [1:0]       bResp;
    logic [1:0]       rResp;
    logic [1:0]       lastResp;
    logic             awValid, awReady, wValid, wReady, bValid, bReady;
    logic             arValid, arReady, rValid, rReady;
    logic             strobe, ampEnabled, ampFollower;
    logic [BinW-1:0]  binSel;
    logic [ThermW-1:0] thermSel;
    logic             supplyRefSwitch, opampRefSwitch, holdCapSwitch;
    logic             emptyIrq, dmaTrig;
    int               failCount;
    int               comparisons;

    dcd_top dut (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .strobe(strobe),
        .ampEnabled(ampEnabled), .ampFollower(ampFollower), .binSel(binSel),
        .thermSel(thermSel), .supplyRefSwitch(supplyRefSwitch),
        .opampRefSwitch(opampRefSwitch), .holdCapSwitch(holdCapSwitch),
        .emptyIrq(emptyIrq), .dmaTrig(dmaTrig)
    );

    always #50 clk = ~clk;

    task automatic wrapUp;
        $display("comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic giveUp(input string what);
        failCount++;
        $display("wrong value at %0t: %s timed out", $time, what);
        wrapUp();
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp,
                             input string what);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp, input string what);
        checkWord({31'h0, got}, {31'h0, exp}, what);
    endtask

    task automatic checkSel(input logic [7:0] b, input logic [14:0] t,
                            input string what);
        checkWord({24'h0, binSel}, {24'h0, b}, what);
        checkWord({17'h0, thermSel}, {17'h0, t}, what);
    endtask

    task automatic axiWrite(input logic [AddrW-1:0] a, input logic [31:0] d);
        logic hsA;
        logic hsW;
        logic done;
        int   n;
        @(posedge clk);
        awAddr <= a;
        awValid <= 1'b1;
        wData <= d;
        wValid <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            hsA = awValid && awReady;
            hsW = wValid && wReady;
            done = bValid;
            lastResp = bResp;
            @(posedge clk);
            if (hsA) awValid <= 1'b0;
            if (hsW) wValid <= 1'b0;
        end
        if (!done) giveUp("write");
    endtask

    task automatic axiRead(input logic [AddrW-1:0] a);
        logic hsA;
        logic done;
        int   n;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(negedge clk);
            hsA = arValid && arReady;
            done = rValid;
            lastData = rData;
            lastResp = rResp;
            @(posedge clk);
            if (hsA) arValid <= 1'b0;
        end
        if (!done) giveUp("read");
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic waitTrig;
        int n;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            if (dmaTrig === 1'b1) break;
        end
        if (n == 100) giveUp("update");
    endtask

    task automatic countTrig(input int cycles, input int exp,
                             input string what);
        int n;
        int cnt;
        cnt = 0;
        for (n = 0; n < cycles; n++) begin
            @(negedge clk);
            if (dmaTrig !== 1'b0) cnt++;
        end
        checkWord(32'(cnt), 32'(exp), what);
    endtask

    task automatic testReset;
        settle();
        checkSel(8'h00, 15'h0000, "selects after reset");
        checkBit(supplyRefSwitch | opampRefSwitch | holdCapSwitch, 1'b0, "sw");
        checkBit(emptyIrq | dmaTrig, 1'b0, "events after reset");
        axiRead(OffCtrl);
        checkWord(lastData, CtrlRst, "ctrl reset");
        axiRead(OffDiv);
        checkWord(lastData, {16'h0, DivRst}, "divider reset");
    endtask

    task automatic testLadder;
        int nib;
        for (nib = 0; nib < 16; nib++) begin
            axiWrite(OffCode, 32'(nib * 256 + nib * 17));
            settle();
            checkSel(8'(nib * 17), 15'((16'h1 << nib) - 1), "code");
        end
        axiWrite(OffCode, 32'hFFFF_F123);
        axiRead(OffCode);
        checkWord(lastData, 32'h0000_0123, "code width");
    endtask

    task automatic testFormat;
        logic [1:0]  f [5] = '{FmtTwos, FmtTwos, FmtTwos, FmtUnsigned, 2'h2};
        logic [11:0] c [5] = '{12'h800, 12'h7FF, 12'h000, 12'h800, 12'h7FF};
        logic [7:0]  b [5] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF};
        logic [14:0] t [5] = '{15'h0000, 15'h7FFF, 15'h00FF, 15'h00FF, 15'h007F};
        int i;
        for (i = 0; i < 5; i++) begin
            axiWrite(OffCtrl, 32'(f[i]) << FmtLsb);
            axiWrite(OffCode, {20'h0, c[i]});
            settle();
            checkSel(b[i], t[i], "format");
        end
        axiWrite(OffCtrl, 32'h0000_0000);
    endtask

    task automatic testSwitch;
        int k;
        axiWrite(OffSwSet, 32'h0000_0005);
        settle();
        checkBit(supplyRefSwitch, 1'b1, "supply close");
        checkBit(holdCapSwitch, 1'b1, "hold close");
        axiWrite(OffSwSet, 32'h0000_0000);
        settle();
        checkBit(supplyRefSwitch, 1'b1, "zero write");
        axiWrite(OffSwClr, 32'h0000_0001);
        settle();
        checkBit(supplyRefSwitch, 1'b0, "supply open");
        checkBit(holdCapSwitch, 1'b1, "hold kept");
        axiWrite(OffSwSet, 32'h0000_0002);
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            ampEnabled <= k[0];
            ampFollower <= k[1];
            settle();
            checkBit(opampRefSwitch, k == 3, "opamp ref");
        end
        axiWrite(OffSwClr, 32'h0000_0006);
        settle();
        checkBit(opampRefSwitch | holdCapSwitch, 1'b0, "open both");
    endtask

    task automatic testBuffered;
        axiWrite(OffDiv, 32'd20);
        axiWrite(OffNext, 32'h0000_05A3);
        axiWrite(OffCtrl, 32'h0000_0001);
        waitTrig();
        checkBit(emptyIrq, 1'b1, "empty raised");
        @(negedge clk);
        checkBit(dmaTrig, 1'b0, "trigger pulse");
        settle();
        checkSel(8'hA3, 15'h001F, "buffered load");
        axiRead(OffStat);
        checkBit(lastData[0], 1'b1, "status empty");
        axiWrite(OffNext, 32'h0000_00C4);
        @(negedge clk);
        checkBit(emptyIrq, 1'b0, "empty cleared");
        waitTrig();
        settle();
        checkSel(8'hC4, 15'h0000, "second load");
        axiWrite(OffCtrl, 32'h0000_0000);
    endtask

    task automatic testStrobe;
        axiWrite(OffDiv, 32'd1);
        axiWrite(OffNext, 32'h0000_0100);
        axiWrite(OffCtrl, 32'h3000_0001);
        countTrig(30, 0, "no strobe");
        @(posedge clk);
        strobe <= 1'b1;
        waitTrig();
        @(posedge clk);
        strobe <= 1'b0;
        settle();
        checkSel(8'h00, 15'h0001, "strobe load");
        axiWrite(OffNext, 32'h0000_0200);
        axiWrite(OffCtrl, 32'h1000_0001);
        countTrig(30, 0, "edge mode idle");
        @(posedge clk);
        strobe <= 1'b1;
        waitTrig();
        countTrig(10, 0, "one load per rise");
        @(posedge clk);
        strobe <= 1'b0;
        settle();
        checkSel(8'h00, 15'h0003, "edge load");
        axiWrite(OffCtrl, 32'h0000_0000);
    endtask

    task automatic testUnmapped;
        axiWrite(5'h1C, 32'hFFFF_FFFF);
        checkWord({30'h0, lastResp}, {30'h0, RespSlvErr}, "write unmapped");
        axiRead(5'h1C);
        checkWord({30'h0, lastResp}, {30'h0, RespSlvErr}, "read unmapped");
        checkWord(lastData, 32'h0000_0000, "unmapped data");
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awAddr, arAddr, wData} = '0;
        {awValid, wValid, arValid, strobe, ampEnabled, ampFollower} = '0;
        bReady = 1'b1;
        rReady = 1'b1;
        failCount = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
        testLadder();
        testFormat();
        testSwitch();
        testBuffered();
        testStrobe();
        testUnmapped();
        wrapUp();
    end
endmodule
`default_nettype wire
